// >>> sfc_pkg.sv
// Constants and types for the serial flash command front end
package sfc_pkg;

  // Opcodes
  localparam logic [7:0] OP_READ       = 8'h03;
  localparam logic [7:0] OP_FAST_READ  = 8'h0B;
  localparam logic [7:0] OP_DUAL_OUT   = 8'h3B;
  localparam logic [7:0] OP_QUAD_OUT   = 8'h6B;
  localparam logic [7:0] OP_DUAL_IO    = 8'hBB;
  localparam logic [7:0] OP_QUAD_IO    = 8'hEB;
  localparam logic [7:0] OP_WORD_QIO   = 8'hE7;
  localparam logic [7:0] OP_VSR_WEN    = 8'h50;
  localparam logic [7:0] OP_RST_EN     = 8'h66;
  localparam logic [7:0] OP_RST_DEV    = 8'h99;
  localparam logic [7:0] OP_DEEP_PD    = 8'hB9;
  localparam logic [7:0] OP_REL_PD     = 8'hAB;
  localparam logic [7:0] OP_WR_EN      = 8'h06;
  localparam logic [7:0] OP_WR_DIS     = 8'h04;

  // Field widths and limits
  localparam int OPCODE_BITS = 8;
  localparam int ADDR_BITS = 24;
  localparam int ARRAY_ADDR_BITS = 22;
  localparam logic [23:0] ADDR_MASK = 24'h3FFFFF;
  localparam logic [7:0] MODE_CONT = 8'hA0;
  localparam logic [7:0] MODE_CONT_MASK = 8'hF0;

  // Clock counts per phase
  localparam logic [5:0] CLK_OPCODE = 6'h08;
  localparam logic [5:0] CLK_ADDR_X1 = 6'h18;
  localparam logic [5:0] CLK_ADDR_X2 = 6'h0C;
  localparam logic [5:0] CLK_ADDR_X4 = 6'h06;
  localparam logic [5:0] CLK_MODE_X2 = 6'h04;
  localparam logic [5:0] CLK_MODE_X4 = 6'h02;
  localparam logic [5:0] CLK_DUMMY_8 = 6'h08;
  localparam logic [5:0] CLK_DUMMY_4 = 6'h04;
  localparam logic [5:0] CLK_DUMMY_2 = 6'h02;
  localparam logic [5:0] CLK_NONE = 6'h00;

  // Lane counts
  localparam logic [2:0] LANE_X1 = 3'h1;
  localparam logic [2:0] LANE_X2 = 3'h2;
  localparam logic [2:0] LANE_X4 = 3'h4;

  // Command codes reported to the core
  typedef enum logic [3:0] {
    CMD_NONE, CMD_READ, CMD_FAST_READ, CMD_DUAL_OUT, CMD_QUAD_OUT,
    CMD_DUAL_IO, CMD_QUAD_IO, CMD_WORD_QIO, CMD_VSR_WEN, CMD_RST_EN,
    CMD_RST_DEV, CMD_DEEP_PD, CMD_REL_PD, CMD_WR_EN, CMD_WR_DIS
  } sfc_cmd_e;

  typedef enum {
    ST_IDLE, ST_OPCODE, ST_ADDR, ST_MODE, ST_DUMMY, ST_DATA, ST_IGNORE
  } sfc_state_e;

endpackage

// >>> sfc_sync.sv
// Two-flop synchroniser for asynchronous inputs
`timescale 1ns/100ps
module sfc_sync #(
  parameter int WIDTH = 1
) (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta_r;
  logic [WIDTH-1:0] sync_r;

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      meta_r <= '0;
      sync_r <= '0;
    end else begin
      meta_r <= async_in;
      sync_r <= meta_r;
    end
  end

  assign sync_out = sync_r;
endmodule

// >>> sfc_front_end.sv
// Serial flash command framing and opcode decode front end
`timescale 1ns/100ps
//
// Overview of operation
// RL1 - Chip select assertion starts a new operation at the first clock edge.
// RL2 - Host sends an 8-bit opcode before any address, mode or data.
// RL3 - Opcode, address and data move most significant bit first.
// RL4 - Chip select release ends the current transaction.
// RL5 - An unsupported opcode starts no operation.
// RL6 - After rejection, input is ignored until chip select cycles.
// RL7 - Release before opcode and address complete aborts quietly to idle.
// RL8 - Addressed commands carry three address bytes forming 24 bits.
// RL9 - The top two address bits are ignored.
// RL10 - 3Bh: single-lane opcode and address, 8 dummy clocks, dual data.
// RL11 - 6Bh: single-lane opcode and address, 8 dummy clocks, quad data.
// RL12 - BBh: address and 4 mode clocks on two lanes; continuous skips opcode.
// RL13 - EBh: address and 2 mode clocks on four lanes, 4 dummy clocks.
// RL14 - E7h: address and 2 mode clocks on four lanes, 2 dummy clocks.
// RL15 - 50h is an opcode-only volatile status_reg write enable.
// RL16 - Inputs sampled on rising clock, outputs change on falling clock.
// RL17 - Quad address takes 6 clocks and the mode byte 2 clocks.
// RL18 - 03h reads with no dummy clocks; 0Bh adds eight dummy clocks.
// RL19 - Opcode-only system commands 66h, 99h, B9h, ABh, 06h, 04h decode.
module sfc_front_end
  import sfc_pkg::*;
(
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic cs_n_in,
  input wire logic sck_in,
  input wire logic [3:0] io_in,
  input wire logic [3:0] tx_nibble_in,
  output logic [3:0] io_out,
  output logic [3:0] io_oe_out,
  output sfc_pkg::sfc_cmd_e cmd_out,
  output logic cmd_valid_out,
  output logic [23:0] addr_out,
  output logic addr_valid_out,
  output logic data_phase_out,
  output logic [2:0] data_lanes_out,
  output logic tx_shift_out,
  output logic [7:0] rx_byte_out,
  output logic rx_byte_valid_out,
  output logic cont_mode_out,
  output logic reject_out
);

  // ----------------------------------------------------------------
  // Reset release and input synchronisers
  // ----------------------------------------------------------------
  logic [1:0] rst_pipe_r;
  logic rst_n;
  logic [5:0] pins_sync;
  logic cs_n_s;
  logic sck_s;
  logic [3:0] io_s;
  logic sck_d_r;
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rst_pipe_r <= 2'h0;
    end else begin
      rst_pipe_r <= {rst_pipe_r[0], 1'b1};
    end
  end
  assign rst_n = rst_pipe_r[1];
  // Select enters inverted so the synchroniser resets to deselected
  sfc_sync #(.WIDTH(6)) u_sync (
    .clk_in(clk_in),
    .rst_n_in(rst_n),
    .async_in({~cs_n_in, sck_in, io_in}),
    .sync_out(pins_sync)
  );
  assign cs_n_s = ~pins_sync[5];
  assign sck_s = pins_sync[4];
  assign io_s = pins_sync[3:0];
  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      sck_d_r <= 1'b0;
    end else begin
      sck_d_r <= sck_s;
    end
  end
  // Sample on rising, drive on falling; sck edges are ignored while deselected
  wire sck_rise = sck_s & ~sck_d_r & ~cs_n_s;  // see RL16
  wire sck_fall = ~sck_s & sck_d_r & ~cs_n_s;  // see RL16
  // ----------------------------------------------------------------
  // Frame state
  // ----------------------------------------------------------------
  sfc_state_e state_r, state_nxt;
  logic [5:0] cnt_r;
  logic [2:0] lanes_r;
  logic [7:0] op_r;
  logic [23:0] addr_r;
  logic [7:0] mode_r;
  logic [7:0] rx_r;
  logic [2:0] rx_cnt_r;
  logic cont_r;
  sfc_cmd_e cont_cmd_r;
  logic [3:0] tx_r;
  logic [3:0] oe_r;
  logic cmd_valid_r;
  logic addr_valid_r;
  logic rx_valid_r;
  logic reject_r;
  sfc_cmd_e cmd_r;
  // Opcode decode on the byte as it completes
  wire [7:0] op_full = {op_r[6:0], io_s[0]};  // see RL3
  sfc_cmd_e dec_cmd;
  always_comb begin
    case (op_full)
      OP_READ: dec_cmd = CMD_READ;             // see RL18
      OP_FAST_READ: dec_cmd = CMD_FAST_READ;   // see RL18
      OP_DUAL_OUT: dec_cmd = CMD_DUAL_OUT;     // see RL10
      OP_QUAD_OUT: dec_cmd = CMD_QUAD_OUT;     // see RL11
      OP_DUAL_IO: dec_cmd = CMD_DUAL_IO;       // see RL12
      OP_QUAD_IO: dec_cmd = CMD_QUAD_IO;       // see RL13
      OP_WORD_QIO: dec_cmd = CMD_WORD_QIO;     // see RL14
      OP_VSR_WEN: dec_cmd = CMD_VSR_WEN;       // see RL15
      OP_RST_EN: dec_cmd = CMD_RST_EN;         // see RL19
      OP_RST_DEV: dec_cmd = CMD_RST_DEV;       // see RL19
      OP_DEEP_PD: dec_cmd = CMD_DEEP_PD;       // see RL19
      OP_REL_PD: dec_cmd = CMD_REL_PD;         // see RL19
      OP_WR_EN: dec_cmd = CMD_WR_EN;           // see RL19
      OP_WR_DIS: dec_cmd = CMD_WR_DIS;         // see RL19
      default: dec_cmd = CMD_NONE;             // see RL5
    endcase
  end
  // Per-command phase shapes
  function automatic logic [2:0] addr_lanes(input sfc_cmd_e c);
    case (c)
      CMD_DUAL_IO: addr_lanes = LANE_X2;
      CMD_QUAD_IO, CMD_WORD_QIO: addr_lanes = LANE_X4;
      default: addr_lanes = LANE_X1;
    endcase
  endfunction
  function automatic logic [5:0] addr_clks(input sfc_cmd_e c);
    case (c)
      CMD_DUAL_IO: addr_clks = CLK_ADDR_X2;
      CMD_QUAD_IO, CMD_WORD_QIO: addr_clks = CLK_ADDR_X4;  // see RL17
      default: addr_clks = CLK_ADDR_X1;
    endcase
  endfunction
  function automatic logic [5:0] dummy_clks(input sfc_cmd_e c);
    case (c)
      CMD_FAST_READ, CMD_DUAL_OUT, CMD_QUAD_OUT: dummy_clks = CLK_DUMMY_8;
      CMD_QUAD_IO: dummy_clks = CLK_DUMMY_4;   // see RL13
      CMD_WORD_QIO: dummy_clks = CLK_DUMMY_2;  // see RL14
      default: dummy_clks = CLK_NONE;          // see RL12
    endcase
  endfunction
  function automatic logic [2:0] data_lanes(input sfc_cmd_e c);
    case (c)
      CMD_DUAL_OUT, CMD_DUAL_IO: data_lanes = LANE_X2;  // see RL10
      CMD_QUAD_OUT, CMD_QUAD_IO, CMD_WORD_QIO: data_lanes = LANE_X4;
      default: data_lanes = LANE_X1;
    endcase
  endfunction
  function automatic logic has_addr(input sfc_cmd_e c);
    has_addr = c inside {CMD_READ, CMD_FAST_READ, CMD_DUAL_OUT,
      CMD_QUAD_OUT, CMD_DUAL_IO, CMD_QUAD_IO, CMD_WORD_QIO};
  endfunction
  wire has_mode = (cmd_r == CMD_DUAL_IO) || (cmd_r == CMD_QUAD_IO) ||
                  (cmd_r == CMD_WORD_QIO);
  wire [5:0] mode_clks = (cmd_r == CMD_DUAL_IO) ? CLK_MODE_X2 : CLK_MODE_X4;
  wire last_clk = (cnt_r == 6'h01);
  // Address shifts in on 1, 2 or 4 lanes, top lane carries the higher bit
  logic [23:0] addr_shift;
  always_comb begin
    case (lanes_r)
      LANE_X2: addr_shift = {addr_r[21:0], io_s[1:0]};
      LANE_X4: addr_shift = {addr_r[19:0], io_s};
      default: addr_shift = {addr_r[22:0], io_s[0]};
    endcase
  end
  logic [7:0] mode_shift;
  always_comb begin
    case (lanes_r)
      LANE_X2: mode_shift = {mode_r[5:0], io_s[1:0]};
      LANE_X4: mode_shift = {mode_r[3:0], io_s};
      default: mode_shift = {mode_r[6:0], io_s[0]};
    endcase
  end
  wire cont_next = ((mode_shift & MODE_CONT_MASK) == MODE_CONT);

  // ----------------------------------------------------------------
  // Phase sequencing
  // ----------------------------------------------------------------
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      ST_IDLE: begin
        if (!cs_n_s) begin
          state_nxt = cont_r ? ST_ADDR : ST_OPCODE;  // see RL1
        end
      end
      ST_OPCODE: begin
        if (sck_rise && last_clk) begin
          state_nxt = has_addr(dec_cmd) ? ST_ADDR : ST_IGNORE;  // see RL6 RL8
        end
      end
      ST_ADDR: begin
        if (sck_rise && last_clk) begin
          state_nxt = has_mode ? ST_MODE :
            (dummy_clks(cmd_r) != CLK_NONE) ? ST_DUMMY : ST_DATA;
        end
      end
      ST_MODE: begin
        if (sck_rise && last_clk) begin
          state_nxt = (dummy_clks(cmd_r) != CLK_NONE) ? ST_DUMMY : ST_DATA;
        end
      end
      ST_DUMMY: begin
        if (sck_rise && last_clk) begin
          state_nxt = ST_DATA;
        end
      end
      ST_DATA, ST_IGNORE: state_nxt = state_r;
      default: state_nxt = ST_IDLE;
    endcase
    if (cs_n_s) begin
      state_nxt = ST_IDLE;  // see RL4 RL7
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  wire enter = (state_r == ST_IDLE) && !cs_n_s;
  wire op_done = (state_r == ST_OPCODE) && sck_rise && last_clk;
  wire addr_done = (state_r == ST_ADDR) && sck_rise && last_clk;
  wire mode_done = (state_r == ST_MODE) && sck_rise && last_clk;
  wire in_data = (state_r == ST_DATA);
  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= ST_IDLE;
      cnt_r <= CLK_NONE;
      lanes_r <= LANE_X1;
      op_r <= 8'h00;
      addr_r <= 24'h000000;
      mode_r <= 8'h00;
      cmd_r <= CMD_NONE;
      cont_r <= 1'b0;
      cont_cmd_r <= CMD_NONE;
      cmd_valid_r <= 1'b0;
      addr_valid_r <= 1'b0;
      reject_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      cmd_valid_r <= 1'b0;
      addr_valid_r <= 1'b0;
      reject_r <= 1'b0;
      if (enter) begin
        op_r <= 8'h00;
        cmd_r <= cont_r ? cont_cmd_r : CMD_NONE;
        lanes_r <= cont_r ? addr_lanes(cont_cmd_r) : LANE_X1;
        // Continuous read skips the opcode phase  see RL12 RL13 RL14
        cnt_r <= cont_r ? addr_clks(cont_cmd_r) : CLK_OPCODE;  // see RL2
        addr_r <= 24'h000000;
        mode_r <= 8'h00;
      end else if (sck_rise) begin
        cnt_r <= cnt_r - 6'h01;
        case (state_r)
          ST_OPCODE: op_r <= op_full;
          ST_ADDR: addr_r <= addr_shift;
          ST_MODE: mode_r <= mode_shift;
          default: op_r <= op_r;
        endcase
      end
      if (op_done) begin
        cmd_r <= dec_cmd;
        lanes_r <= addr_lanes(dec_cmd);
        cnt_r <= addr_clks(dec_cmd);
        reject_r <= (dec_cmd == CMD_NONE);       // see RL5
        cmd_valid_r <= (dec_cmd != CMD_NONE) && !has_addr(dec_cmd);
      end
      if (addr_done) begin
        cnt_r <= has_mode ? mode_clks : dummy_clks(cmd_r);
        // Only commit once opcode and address are complete  see RL7
        cmd_valid_r <= 1'b1;
        addr_valid_r <= 1'b1;
      end
      if (mode_done) begin
        cnt_r <= dummy_clks(cmd_r);
        // Mode byte decides whether the next frame drops the opcode
        cont_r <= cont_next;
        cont_cmd_r <= cmd_r;
      end
    end
  end
  // Upper two bits never reach the array
  assign addr_out = addr_r & ADDR_MASK;  // see RL9
  // ----------------------------------------------------------------
  // Data phase: shift lane 0 in as bytes in every data phase, drive read data
  // ----------------------------------------------------------------
  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      rx_r <= 8'h00;
      rx_cnt_r <= 3'h0;
      rx_valid_r <= 1'b0;
      tx_r <= 4'h0;
      oe_r <= 4'h0;
    end else begin
      rx_valid_r <= 1'b0;
      if (!in_data) begin
        rx_cnt_r <= 3'h0;
        oe_r <= 4'h0;
      end else if (sck_rise) begin
        rx_r <= {rx_r[6:0], io_s[0]};  // see RL3
        rx_cnt_r <= rx_cnt_r + 3'h1;
        rx_valid_r <= (rx_cnt_r == 3'h7);
      end
      // Outputs only move on the falling edge, except that enables clear at deselect  see RL16
      if (in_data && sck_fall && has_addr(cmd_r)) begin
        tx_r <= tx_nibble_in;
        case (data_lanes(cmd_r))
          LANE_X2: oe_r <= 4'h3;
          LANE_X4: oe_r <= 4'hF;
          default: oe_r <= 4'h2;
        endcase
      end
    end
  end

  // Read-data source is told to advance on each falling edge of the data phase
  assign tx_shift_out = in_data && sck_fall && has_addr(cmd_r);
  assign io_out = tx_r;
  assign io_oe_out = cs_n_s ? 4'h0 : oe_r;
  assign cmd_out = cmd_r;
  assign cmd_valid_out = cmd_valid_r;
  assign addr_valid_out = addr_valid_r;
  assign data_phase_out = in_data;
  assign data_lanes_out = data_lanes(cmd_r);
  assign rx_byte_out = rx_r;
  assign rx_byte_valid_out = rx_valid_r;
  assign cont_mode_out = cont_r;
  assign reject_out = reject_r;

endmodule

// >>> sfc_front_end_chk.sv
// Port-level assertions for the command front end
`timescale 1ns/100ps
module sfc_front_end_chk
  import sfc_pkg::*;
(
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic cs_n_in,
  input wire logic sck_in,
  input wire logic [3:0] tx_nibble_in,
  input wire logic [3:0] io_out,
  input wire logic [3:0] io_oe_out,
  input wire sfc_pkg::sfc_cmd_e cmd_out,
  input wire logic cmd_valid_out,
  input wire logic [23:0] addr_out,
  input wire logic addr_valid_out,
  input wire logic data_phase_out,
  input wire logic [2:0] data_lanes_out,
  input wire logic tx_shift_out,
  input wire logic reject_out
);
  import sfc_pkg::*;
  logic [2:0] lanes_exp;
  logic [3:0] oe_exp;
  assign lanes_exp = (cmd_out inside {CMD_QUAD_OUT, CMD_QUAD_IO, CMD_WORD_QIO})
    ? LANE_X4 : (cmd_out inside {CMD_DUAL_OUT, CMD_DUAL_IO}) ? LANE_X2 : LANE_X1;
  assign oe_exp = (data_lanes_out == LANE_X4) ? 4'hF :
    (data_lanes_out == LANE_X2) ? 4'h3 : 4'h2;
  default clocking @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);
  chk_oe_idle: assert property (
    cs_n_in [*5] |-> io_oe_out == 4'h0 && !data_phase_out)
    else $error("Lanes driven while deselected");
  chk_reject_alone: assert property (
    reject_out |-> !cmd_valid_out && !addr_valid_out && !data_phase_out)
    else $error("Rejected opcode started an operation");
  chk_reject_quiet: assert property (
    reject_out |=> (!cmd_valid_out && !addr_valid_out && !data_phase_out) [*8])
    else $error("Input acted on after a reject");
  chk_addr_mask: assert property (
    addr_valid_out |-> addr_out[23:22] == 2'h0)
    else $error("Top address bits not cleared");
  chk_addr_cmd: assert property (
    addr_valid_out |-> cmd_valid_out)
    else $error("Address completed without a command");
  chk_lane_count: assert property (
    data_phase_out |-> data_lanes_out == lanes_exp)
    else $error("Data lane count does not fit the command");
  chk_shift_fall: assert property (
    tx_shift_out |-> !sck_in && data_phase_out)
    else $error("Output shift outside a low clock in data phase");
  chk_oe_width: assert property (
    tx_shift_out |=> io_oe_out == oe_exp)
    else $error("Wrong lanes enabled for data");
  chk_quad_data: assert property (
    tx_shift_out && data_lanes_out == LANE_X4
      |=> io_out == $past(tx_nibble_in))
    else $error("Quad nibble not driven as given");
endmodule

bind sfc_front_end sfc_front_end_chk sfc_front_end_chk_i (
  .clk_in(clk_in), .rst_n_in(rst_n_in), .cs_n_in(cs_n_in), .sck_in(sck_in),
  .tx_nibble_in(tx_nibble_in), .io_out(io_out), .io_oe_out(io_oe_out),
  .cmd_out(cmd_out), .cmd_valid_out(cmd_valid_out), .addr_out(addr_out),
  .addr_valid_out(addr_valid_out), .data_phase_out(data_phase_out),
  .data_lanes_out(data_lanes_out), .tx_shift_out(tx_shift_out),
  .reject_out(reject_out)
);

// >>> sfc_host.sv
// Host controller model driving select, serial clock and lanes
`timescale 1ns/100ps
module sfc_host (
  input wire logic clk_in,
  output logic cs_n_out,
  output logic sck_out,
  output logic [3:0] io_out
);
  initial begin
    cs_n_out = 1'b1;
    sck_out = 1'b0;
    io_out = 4'h0;
  end
  // Clock rests low outside frames
  task automatic select;
    cs_n_out <= 1'b0;
    repeat (8) @(posedge clk_in);
  endtask
  // MSB first; data moves with the fall, device takes it on the rise
  task automatic shift(input logic [31:0] v, input int n, input int w);
    int k;
    for (k = n - 1; k >= 0; k--) begin
      io_out <= 4'((v >> (k * w)) & ((32'h1 << w) - 1));
      repeat (8) @(posedge clk_in);
      sck_out <= 1'b1;
      repeat (8) @(posedge clk_in);
      sck_out <= 1'b0;
    end
  endtask
  task automatic deselect;
    cs_n_out <= 1'b1;
    io_out <= ~io_out; // Released lanes must not hold stale data
    repeat (10) @(posedge clk_in);
  endtask
endmodule

// >>> serial_flash_command_front_end_test.sv
// Self-checking bench for the command front end
`timescale 1ns/100ps
module serial_flash_command_front_end_test;
  import sfc_pkg::*;
  logic clk_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic cs_n, sck, cmd_valid_out, addr_valid_out, data_phase_out;
  logic tx_shift_out, reject_out, cont_mode_out;
  logic [3:0] host_io, io_pin, io_out, io_oe_out;
  logic [3:0] tx_nib = 4'h5;
  logic [23:0] addr_out;
  logic [23:0] seen_addr = 24'h0;
  logic [2:0] data_lanes_out;
  logic rx_byte_valid_out;
  logic [7:0] rx_byte_out;
  logic [7:0] seen_rx = 8'h00;
  int n_rx = 0;
  sfc_cmd_e cmd_out;
  sfc_cmd_e seen_cmd = CMD_NONE;
  int error_cnt = 0, n_compared = 0, n_cmd = 0, n_shift = 0, n_rej = 0;
  always #5 clk_in = ~clk_in;
  // Device drive wins on a lane it enables
  assign io_pin = (io_oe_out & io_out) | (~io_oe_out & host_io);
  sfc_host sfc_host_i (.clk_in(clk_in), .cs_n_out(cs_n), .sck_out(sck),
    .io_out(host_io));
  sfc_front_end sfc_front_end_i (.clk_in(clk_in), .rst_n_in(rst_n_in),
    .cs_n_in(cs_n), .sck_in(sck), .io_in(io_pin), .tx_nibble_in(tx_nib),
    .io_out(io_out), .io_oe_out(io_oe_out), .cmd_out(cmd_out),
    .cmd_valid_out(cmd_valid_out), .addr_out(addr_out),
    .addr_valid_out(addr_valid_out), .data_phase_out(data_phase_out),
    .data_lanes_out(data_lanes_out), .tx_shift_out(tx_shift_out),
    .rx_byte_out(rx_byte_out), .rx_byte_valid_out(rx_byte_valid_out),
    .cont_mode_out(cont_mode_out),
    .reject_out(reject_out));
  always @(posedge clk_in) begin
    if (cmd_valid_out === 1'b1) begin
      n_cmd <= n_cmd + 1;
      seen_cmd <= cmd_out;
    end
    if (addr_valid_out === 1'b1)
      seen_addr <= addr_out;
    if (reject_out === 1'b1)
      n_rej <= n_rej + 1;
    if (tx_shift_out === 1'b1) begin
      n_shift <= n_shift + 1;
      tx_nib <= ~tx_nib;
    end
    if (rx_byte_valid_out === 1'b1) begin
      n_rx <= n_rx + 1;
      seen_rx <= rx_byte_out;
    end
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      $display("Error at %0t: got %h, expected %h", $time, seen, exp);
      error_cnt++;
    end
  endtask
  task automatic give_verdict;
    $display("Compared %0d, errors %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic do_read(input logic [7:0] op, input sfc_cmd_e cmd,
      input int aw, mclk, dclk, dw, input logic [7:0] mode, input bit skip);
    int c0, s0, x0;
    logic [23:0] a;
    a = {2'b11, op, 14'h1A5};
    c0 = n_cmd;
    sfc_host_i.select();
    if (!skip)
      sfc_host_i.shift(op, 8, 1);
    sfc_host_i.shift(a, 24 / aw, aw);
    if (mclk > 0)
      sfc_host_i.shift(mode, mclk, aw);
    if (dclk > 0)
      sfc_host_i.shift(0, dclk, 1);
    s0 = n_shift;
    x0 = n_rx;
    sfc_host_i.shift(32'hA5, 8, dw);
    repeat (6) @(posedge clk_in);
    check(n_cmd - c0, 1);
    check(seen_cmd, cmd);
    check(seen_addr, a & ADDR_MASK);
    check(data_lanes_out, dw);
    check(n_shift - s0, 9);
    check(n_rx - x0, 1);
    if (dw == 1)
      check(seen_rx, 8'hA5);
    check(data_phase_out, 1'b1);
    sfc_host_i.deselect();
    check(io_oe_out, 4'h0);
  endtask
  task automatic t_sys;
    logic [7:0] ops [7] = '{8'h50, 8'h66, 8'h99, 8'hB9, 8'hAB, 8'h06, 8'h04};
    sfc_cmd_e cmds [7] = '{CMD_VSR_WEN, CMD_RST_EN, CMD_RST_DEV, CMD_DEEP_PD,
      CMD_REL_PD, CMD_WR_EN, CMD_WR_DIS};
    for (int i = 0; i < 7; i++) begin
      sfc_host_i.select();
      sfc_host_i.shift(ops[i], 8, 1);
      repeat (4) @(posedge clk_in);
      check(seen_cmd, cmds[i]);
      sfc_host_i.deselect();
    end
  endtask
  task automatic t_reads;
    do_read(OP_READ, CMD_READ, 1, 0, 0, 1, 8'h00, 1'b0);
    do_read(OP_FAST_READ, CMD_FAST_READ, 1, 0, 8, 1, 8'h00, 1'b0);
    do_read(OP_DUAL_OUT, CMD_DUAL_OUT, 1, 0, 8, 2, 8'h00, 1'b0);
    do_read(OP_QUAD_OUT, CMD_QUAD_OUT, 1, 0, 8, 4, 8'h00, 1'b0);
    do_read(OP_WORD_QIO, CMD_WORD_QIO, 4, 2, 2, 4, 8'h00, 1'b0);
  endtask
  task automatic t_cont;
    do_read(OP_DUAL_IO, CMD_DUAL_IO, 2, 4, 0, 2, 8'hA0, 1'b0);
    check(cont_mode_out, 1'b1);
    do_read(OP_DUAL_IO, CMD_DUAL_IO, 2, 4, 0, 2, 8'h00, 1'b1);
    check(cont_mode_out, 1'b0);
    do_read(OP_QUAD_IO, CMD_QUAD_IO, 4, 2, 4, 4, 8'hA5, 1'b0);
    do_read(OP_QUAD_IO, CMD_QUAD_IO, 4, 2, 4, 4, 8'h00, 1'b1);
    do_read(OP_READ, CMD_READ, 1, 0, 0, 1, 8'h00, 1'b0);
  endtask
  task automatic t_reject;
    int c0, r0;
    c0 = n_cmd;
    r0 = n_rej;
    sfc_host_i.select();
    sfc_host_i.shift(8'hFF, 8, 1);
    sfc_host_i.shift(32'h0312_3456, 32, 1);
    repeat (6) @(posedge clk_in);
    check(n_rej - r0, 1);
    check(n_cmd - c0, 0);
    check(data_phase_out, 1'b0);
    sfc_host_i.deselect();
  endtask
  task automatic t_abort;
    int c0;
    c0 = n_cmd;
    sfc_host_i.select();
    sfc_host_i.shift(OP_READ, 8, 1);
    sfc_host_i.shift(32'h155, 10, 1);
    sfc_host_i.deselect();
    check(n_cmd - c0, 0);
    check(data_phase_out, 1'b0);
    sfc_host_i.select();
    sfc_host_i.shift(OP_WR_EN, 8, 1);
    repeat (4) @(posedge clk_in);
    check(seen_cmd, CMD_WR_EN);
    check(n_cmd - c0, 1);
    sfc_host_i.deselect();
  endtask
  initial begin
    repeat (60000) @(posedge clk_in);
    error_cnt++;
    give_verdict();
  end
  initial begin
    repeat (12) @(posedge clk_in);
    rst_n_in <= 1'b1;
    repeat (8) @(posedge clk_in);
    check(cmd_out, CMD_NONE);
    t_sys();
    t_reads();
    t_cont();
    t_reject();
    t_abort();
    give_verdict();
  end
endmodule
